/* common/tbl_interp_pkg.sv */
// constants, register map and state codes of the unsigned table interpolate datapath
`default_nettype none
package tbl_interp_pkg;

  // apb register byte offsets
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_OPWORD   = 8'h04;
  localparam logic [7:0] OFS_EXTWORD  = 8'h08;
  localparam logic [7:0] OFS_DEST     = 8'h0c;
  localparam logic [7:0] OFS_EABASE   = 8'h10;
  localparam logic [7:0] OFS_ENDPT_M  = 8'h14;
  localparam logic [7:0] OFS_ENDPT_N  = 8'h18;
  localparam logic [7:0] OFS_CCR      = 8'h1c;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h20;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h24;

  // control and interrupt bit positions
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_BUSY_BIT  = 0;
  localparam int IRQ_DONE_BIT   = 0;
  localparam int IRQ_ILLEGAL_BIT = 1;
  localparam int IRQ_W          = 2;

  // condition code bits: extend, negative, zero, overflow, carry
  localparam int CCR_X = 4;
  localparam int CCR_N = 3;
  localparam int CCR_Z = 2;
  localparam int CCR_V = 1;
  localparam int CCR_C = 0;
  localparam int CCR_W = 5;

  // reset values
  localparam logic [31:0]      RST_WORD = 32'h0000_0000;
  localparam logic [15:0]      RST_HALF = 16'h0000;
  localparam logic [CCR_W-1:0] RST_CCR  = 5'h00;
  localparam logic [IRQ_W-1:0] RST_IRQ  = 2'h0;

  // operation size codes
  localparam logic [1:0] SIZE_BYTE = 2'b00;
  localparam logic [1:0] SIZE_WORD = 2'b01;
  localparam logic [1:0] SIZE_LONG = 2'b10;

  // operation word: fixed upper ten bits and effective address fields
  localparam logic [9:0] OPWORD_MATCH = 10'h3e0;
  localparam int OP_FIX_HI  = 15;
  localparam int OP_FIX_LO  = 6;
  localparam int OP_MODE_HI = 5;
  localparam int OP_MODE_LO = 3;
  localparam int OP_REG_HI  = 2;
  localparam int OP_REG_LO  = 0;

  // extension word fields
  localparam int EXT_ZERO15   = 15;
  localparam int EXT_SIGNED   = 11;
  localparam int EXT_ROUND    = 10;
  localparam int EXT_ZERO9    = 9;
  localparam int EXT_TABLE    = 8;
  localparam int EXT_SIZE_HI  = 7;
  localparam int EXT_SIZE_LO  = 6;
  localparam int EXT_ZERO_HI  = 5;
  localparam int EXT_ZERO_LO  = 3;

  // effective address mode codes: data register mode and the modes that qualify as control modes
  localparam logic [2:0] EA_MODE_DREG   = 3'b000;
  localparam logic [2:0] EA_MODE_IND    = 3'b010;
  localparam logic [2:0] EA_MODE_DISP   = 3'b101;
  localparam logic [2:0] EA_MODE_INDEX  = 3'b110;
  localparam logic [2:0] EA_MODE_EXT    = 3'b111;
  localparam logic [2:0] EA_EXT_LAST    = 3'b011;

  // independent variable layout: integer byte over fraction byte
  localparam int FRAC_HI = 7;
  localparam int FRAC_LO = 0;
  localparam int INT_HI  = 15;
  localparam int INT_LO  = 8;

  // interpolation arithmetic
  localparam int          ACC_W     = 42;
  localparam logic [41:0] ROUND_HALF = 42'h000_0000_0080;

  // sequencer states
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_READ0 = 2'b01,
    ST_READ1 = 2'b10,
    ST_CALC  = 2'b11
  } state_e;

endpackage
`default_nettype wire

/* hw/tbl_decode.sv */
// decode and addressing mode check of the instruction words
`timescale 1ns/10ps
`default_nettype none
module tbl_decode
  import tbl_interp_pkg::*;
(
  // instruction words
  input  wire logic [15:0] opWord,
  input  wire logic [15:0] extWord,
  // decoded fields
  output logic             tableMode,
  output logic             roundOff,
  output logic [1:0]       sizeCode,
  output logic             legal
);

  wire logic [2:0] eaMode   = opWord[OP_MODE_HI:OP_MODE_LO];
  wire logic [2:0] eaReg    = opWord[OP_REG_HI:OP_REG_LO];
  wire logic       fixOk    = (opWord[OP_FIX_HI:OP_FIX_LO] == OPWORD_MATCH);
  wire logic       regMode  = (eaMode == EA_MODE_DREG);
  wire logic       sizeOk   = (sizeCode != 2'b11);
  wire logic       zeroOk;
  wire logic       ctrlMode;
  wire logic       variantOk;

  // field extraction
  assign tableMode = extWord[EXT_TABLE];
  assign roundOff  = extWord[EXT_ROUND];
  assign sizeCode  = extWord[EXT_SIZE_HI:EXT_SIZE_LO];

  // fixed zero bits, and the unsigned flavour only
  assign zeroOk = ~extWord[EXT_ZERO15] & ~extWord[EXT_ZERO9] & ~extWord[EXT_SIGNED]
                & (extWord[EXT_ZERO_HI:EXT_ZERO_LO] == 3'b000);

  // only control modes address a table
  assign ctrlMode = (eaMode == EA_MODE_IND) | (eaMode == EA_MODE_DISP)
                  | (eaMode == EA_MODE_INDEX)
                  | ((eaMode == EA_MODE_EXT) & (eaReg <= EA_EXT_LAST));

  // mode field zero means register variant, table bit must agree
  assign variantOk = regMode ? ~tableMode : (tableMode & ctrlMode);

  assign legal = fixOk & zeroOk & sizeOk & variantOk;

endmodule // tbl_decode
`default_nettype wire

/* hw/tbl_interp_core.sv */
// interpolation arithmetic, result placement and flag evaluation
`timescale 1ns/10ps
`default_nettype none
module tbl_interp_core
  import tbl_interp_pkg::*;
(
  // operands
  input  wire logic [31:0] entryLo,
  input  wire logic [31:0] entryHi,
  input  wire logic [7:0]  frac,
  input  wire logic [1:0]  sizeCode,
  input  wire logic        roundOff,
  input  wire logic [31:0] destIn,
  // results
  output logic [31:0]      destOut,
  output logic             negFlag,
  output logic             zeroFlag,
  output logic             ovfFlag
);

  wire logic [31:0]        sizeMask;
  wire logic [31:0]        e0;
  wire logic [31:0]        e1;
  wire logic [ACC_W-1:0]   e0x;
  wire logic [ACC_W-1:0]   diff;
  wire logic [ACC_W-1:0]   prod;
  wire logic [ACC_W-1:0]   unr;
  wire logic [ACC_W-1:0]   rnd;
  wire logic [31:0]        rndVal;
  wire logic [31:0]        rndOut;
  wire logic [31:0]        unrOut;
  wire logic               rndMsb;

  // entries are unsigned at the operation width
  assign sizeMask = (sizeCode == SIZE_BYTE) ? 32'h0000_00ff :
                    (sizeCode == SIZE_WORD) ? 32'h0000_ffff : 32'hffff_ffff;
  assign e0 = entryLo & sizeMask;
  assign e1 = entryHi & sizeMask;

  // signed difference scaled by the fraction, added to entry times 256
  assign e0x  = {10'h000, e0};
  assign diff = e1x_minus(e0x, {10'h000, e1});
  assign prod = ACC_W'($signed(diff) * $signed({34'h0, frac}));
  assign unr  = {e0x[ACC_W-9:0], 8'h00} + prod;

  // half an lsb added before dropping the fraction: below half +0, else +1
  assign rnd    = unr + ROUND_HALF;
  assign rndVal = rnd[39:8];

  // rounded form touches only the sized part of the destination
  assign rndOut = (sizeCode == SIZE_BYTE) ? {destIn[31:8], rndVal[7:0]} :
                  (sizeCode == SIZE_WORD) ? {destIn[31:16], rndVal[15:0]} : rndVal;
  assign rndMsb = (sizeCode == SIZE_BYTE) ? rndVal[7] :
                  (sizeCode == SIZE_WORD) ? rndVal[15] : rndVal[31];

  // unrounded form: fraction low, integer above, zero filled
  assign unrOut = (sizeCode == SIZE_BYTE) ? {16'h0000, unr[15:0]} :
                  (sizeCode == SIZE_WORD) ? {8'h00, unr[23:0]} : unr[31:0];

  assign destOut = roundOff ? unrOut : rndOut;

  // flags judge the sized result
  assign negFlag  = roundOff ? unrOut[31] : rndMsb;
  assign zeroFlag = roundOff ? (unrOut == 32'h0) : ((rndVal & sizeMask) == 32'h0);
  assign ovfFlag  = roundOff & (sizeCode == SIZE_LONG) & (unr[39:32] != 8'h00);

  // difference helper keeps the subtraction at accumulator width
  function automatic logic [ACC_W-1:0] e1x_minus(input logic [ACC_W-1:0] lo,
                                                 input logic [ACC_W-1:0] hi);
    e1x_minus = hi - lo;
  endfunction

endmodule // tbl_interp_core
`default_nettype wire

/* hw/unsigned_table_interpolate.sv */
// unsigned table lookup and interpolate datapath with apb registers
`timescale 1ns/10ps
`default_nettype none
module unsigned_table_interpolate
  import tbl_interp_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  // clock and reset
  input  wire logic              clk_sys,
  input  wire logic              reset,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  // table entry read port
  output logic                   memReq,
  output logic [31:0]            memAddr,
  output logic [1:0]             memSize,
  input  wire logic              memAck,
  input  wire logic [31:0]       memRdata,
  // interrupt
  output logic                   irq
);

  // architectural state
  state_e                state_r;
  state_e                state_nxt;
  logic [15:0]           opWord_r;
  logic [15:0]           extWord_r;
  logic [31:0]           destOperandReg_r;
  logic [31:0]           eaBase_r;
  logic [31:0]           endptM_r;
  logic [31:0]           endptN_r;
  logic [31:0]           entry0_r;
  logic [31:0]           entry1_r;
  logic [CCR_W-1:0]      ccr_r;
  logic [IRQ_W-1:0]      irqStat_r;
  logic [IRQ_W-1:0]      irqMask_r;
  logic [31:0]           prdata_r;
  logic [31:0]           memAddr_r;

  // apb phase and decode wires
  wire logic             setupPh = psel & ~penable;
  wire logic             accessPh = psel & penable;
  wire logic [7:0]       regOfs = 8'(paddr);
  wire logic             hitCtrl  = (regOfs == OFS_CTRL);
  wire logic             hitOp    = (regOfs == OFS_OPWORD);
  wire logic             hitExt   = (regOfs == OFS_EXTWORD);
  wire logic             hitDest  = (regOfs == OFS_DEST);
  wire logic             hitEa    = (regOfs == OFS_EABASE);
  wire logic             hitM     = (regOfs == OFS_ENDPT_M);
  wire logic             hitN     = (regOfs == OFS_ENDPT_N);
  wire logic             hitCcr   = (regOfs == OFS_CCR);
  wire logic             hitStat  = (regOfs == OFS_IRQ_STAT);
  wire logic             hitMask  = (regOfs == OFS_IRQ_MASK);
  wire logic             hitAny;
  wire logic             busy;
  wire logic             wrAcc;
  wire logic             wrOperand;
  wire logic             rdStat;
  wire logic             startReq;

  assign hitAny = hitCtrl | hitOp | hitExt | hitDest | hitEa | hitM | hitN
                | hitCcr | hitStat | hitMask;
  assign busy      = (state_r != ST_IDLE);
  assign wrAcc     = accessPh & pwrite & hitAny;
  // operands are frozen while an operation runs, so the datapath never sees a torn value
  assign wrOperand = wrAcc & ~busy;
  assign rdStat    = accessPh & ~pwrite & hitStat;
  assign startReq  = wrOperand & hitCtrl & pwdata[CTRL_START_BIT];

  // zero wait state slave, error only on an unmapped word
  assign pready  = 1'b1;
  assign pslverr = accessPh & ~hitAny;
  assign prdata  = prdata_r;

  // decoded instruction
  wire logic             tableMode;
  wire logic             roundOff;
  wire logic [1:0]       sizeCode;
  wire logic             legal;

  tbl_decode u_decode (
    .opWord    (opWord_r),
    .extWord   (extWord_r),
    .tableMode (tableMode),
    .roundOff  (roundOff),
    .sizeCode  (sizeCode),
    .legal     (legal)
  );

  // independent variable split at the binary point
  wire logic [7:0]       fracPart = destOperandReg_r[FRAC_HI:FRAC_LO];
  wire logic [7:0]       intPart  = destOperandReg_r[INT_HI:INT_LO];
  wire logic [31:0]      entryStride;
  wire logic [31:0]      entryAddr0;
  wire logic [31:0]      entryAddr1;
  wire logic [31:0]      sizeBytes;

  // scaled index: one, two or four bytes per entry
  assign sizeBytes   = 32'h0000_0001 << sizeCode;
  assign entryStride = 32'({24'h000000, intPart} << sizeCode);
  assign entryAddr0  = eaBase_r + entryStride;
  assign entryAddr1  = entryAddr0 + sizeBytes;

  // endpoints come from memory in table mode, from registers otherwise
  wire logic [31:0]      opLo = tableMode ? entry0_r : endptM_r;
  wire logic [31:0]      opHi = tableMode ? entry1_r : endptN_r;
  wire logic [31:0]      destOut;
  wire logic             negFlag;
  wire logic             zeroFlag;
  wire logic             ovfFlag;

  tbl_interp_core u_core (
    .entryLo  (opLo),
    .entryHi  (opHi),
    .frac     (fracPart),
    .sizeCode (sizeCode),
    .roundOff (roundOff),
    .destIn   (destOperandReg_r),
    .destOut  (destOut),
    .negFlag  (negFlag),
    .zeroFlag (zeroFlag),
    .ovfFlag  (ovfFlag)
  );

  // sequencer events
  wire logic             startLegal = startReq & legal;
  wire logic             startBad   = startReq & ~legal;
  wire logic             finish     = (state_r == ST_CALC);
  wire logic             read0Done  = (state_r == ST_READ0) & memAck;
  wire logic             read1Done  = (state_r == ST_READ1) & memAck;
  wire logic [IRQ_W-1:0] irqEvents;

  assign irqEvents = {startBad, finish};

  // next state: table mode fetches two entries, register mode goes straight to compute
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:
      begin
        if (startLegal)
        begin
          state_nxt = tableMode ? ST_READ0 : ST_CALC;
        end
      end
      ST_READ0:
      begin
        if (memAck)
        begin
          state_nxt = ST_READ1;
        end
      end
      ST_READ1:
      begin
        if (memAck)
        begin
          state_nxt = ST_CALC;
        end
      end
      ST_CALC:
      begin
        state_nxt = ST_IDLE;
      end
      default:
      begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // entry address is held steady for the whole request
  wire logic [31:0]      memAddr_nxt;

  assign memAddr_nxt = (startLegal & tableMode) ? entryAddr0 :
                       read0Done ? entryAddr1 : memAddr_r;
  assign memReq  = (state_r == ST_READ0) | (state_r == ST_READ1);
  assign memAddr = memAddr_r;
  assign memSize = sizeCode;

  // sequencer and entry capture
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      state_r   <= ST_IDLE;
      memAddr_r <= RST_WORD;
      entry0_r  <= RST_WORD;
      entry1_r  <= RST_WORD;
    end
    else
    begin
      state_r   <= state_nxt;
      memAddr_r <= memAddr_nxt;
      if (read0Done)
      begin
        entry0_r <= memRdata;
      end
      if (read1Done)
      begin
        entry1_r <= memRdata;
      end
    end
  end

  // software written operand registers
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      opWord_r  <= RST_HALF;
      extWord_r <= RST_HALF;
      eaBase_r  <= RST_WORD;
      endptM_r  <= RST_WORD;
      endptN_r  <= RST_WORD;
      irqMask_r <= RST_IRQ;
    end
    else
    begin
      if (wrOperand & hitOp)
      begin
        opWord_r <= pwdata[15:0];
      end
      if (wrOperand & hitExt)
      begin
        extWord_r <= pwdata[15:0];
      end
      if (wrOperand & hitEa)
      begin
        eaBase_r <= pwdata;
      end
      if (wrOperand & hitM)
      begin
        endptM_r <= pwdata;
      end
      if (wrOperand & hitN)
      begin
        endptN_r <= pwdata;
      end
      if (wrAcc & hitMask)
      begin
        irqMask_r <= pwdata[IRQ_W-1:0];
      end
    end
  end

  // destination and condition codes: software value, or the finished result
  wire logic [31:0]      dest_nxt;
  wire logic [CCR_W-1:0] ccr_nxt;
  wire logic [CCR_W-1:0] ccrResult;

  // extend kept, carry always cleared
  assign ccrResult = {ccr_r[CCR_X], negFlag, zeroFlag, ovfFlag, 1'b0};
  assign dest_nxt  = finish ? destOut :
                     (wrOperand & hitDest) ? pwdata : destOperandReg_r;
  assign ccr_nxt   = finish ? ccrResult :
                     (wrOperand & hitCcr) ? pwdata[CCR_W-1:0] : ccr_r;

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      destOperandReg_r <= RST_WORD;
      ccr_r            <= RST_CCR;
    end
    else
    begin
      destOperandReg_r <= dest_nxt;
      ccr_r            <= ccr_nxt;
    end
  end

  // read data is latched in the setup phase so prdata comes from a flop
  wire logic [31:0]      readMux;

  assign readMux = hitCtrl ? {31'h0, busy} :
                   hitOp   ? {16'h0000, opWord_r} :
                   hitExt  ? {16'h0000, extWord_r} :
                   hitDest ? destOperandReg_r :
                   hitEa   ? eaBase_r :
                   hitM    ? endptM_r :
                   hitN    ? endptN_r :
                   hitCcr  ? {27'h0, ccr_r} :
                   hitStat ? {30'h0, irqStat_r} :
                   hitMask ? {30'h0, irqMask_r} : 32'h0;

  // a read clears only the bits it reported; a new event in the same cycle survives
  wire logic [IRQ_W-1:0] statClr = rdStat ? prdata_r[IRQ_W-1:0] : RST_IRQ;
  wire logic [IRQ_W-1:0] irqStat_nxt = (irqStat_r & ~statClr) | irqEvents;

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      prdata_r  <= RST_WORD;
      irqStat_r <= RST_IRQ;
    end
    else
    begin
      irqStat_r <= irqStat_nxt;
      if (setupPh & ~pwrite)
      begin
        prdata_r <= readMux;
      end
    end
  end

  // level interrupt while any unmasked status bit is set
  assign irq = |(irqStat_r & irqMask_r);

endmodule // unsigned_table_interpolate
`default_nettype wire

/* tb/tbl_mem_model.sv */
// table memory model answering the entry read port
`timescale 1ns/10ps
`default_nettype none
module tbl_mem_model
(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset,
  // entry read port
  input  wire logic        memReq,
  input  wire logic [31:0] memAddr,
  input  wire logic [1:0]  memSize,
  output logic             memAck,
  output logic [31:0]      memRdata,
  // contents and pace chosen by the bench
  input  wire logic [31:0] addr0,
  input  wire logic [31:0] ent0,
  input  wire logic [31:0] ent1,
  input  wire logic [3:0]  lat
);
  logic [3:0]  waitCnt_r;
  logic [31:0] word;

  // entry n at addr0, entry n+1 one size further; other addresses get junk
  assign word = (memAddr == addr0) ? ent0 :
                (memAddr == addr0 + (32'h1 << memSize)) ? ent1 : 32'h5a5a_5a5a;
  // bus shows inverted data outside the ack cycle, so late sampling fails
  assign memRdata = memAck ? word : ~word;

  // ack after lat+1 waiting cycles of the request, one cycle wide
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      waitCnt_r <= 4'h0;
      memAck    <= 1'b0;
    end
    else
    begin
      memAck <= 1'b0;
      if (memReq && !memAck)
      begin
        memAck    <= (waitCnt_r == lat);
        waitCnt_r <= (waitCnt_r == lat) ? 4'h0 : waitCnt_r + 4'h1;
      end
    end
  end
endmodule // tbl_mem_model
`default_nettype wire

/* tb/unsigned_table_interpolate_bench.sv */
// self-checking bench of the unsigned table interpolate datapath
`timescale 1ns/10ps
`default_nettype none
module unsigned_table_interpolate_bench;
  import tbl_interp_pkg::*;
  logic        clk_sys = 1'b0;
  logic        reset, psel, penable, pwrite, memReq, memAck, pready, pslverr, irq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, memAddr, memRdata, rdv, addr0, ent0, ent1;
  logic [1:0]  memSize;
  logic [3:0]  lat;
  logic        errv, irqOn;
  int          badCount, comparisons;

  unsigned_table_interpolate #(.ADDR_W(8)) i_dut (.clk_sys(clk_sys), .reset(reset),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .memReq(memReq),
    .memAddr(memAddr), .memSize(memSize), .memAck(memAck), .memRdata(memRdata), .irq(irq));
  tbl_mem_model i_mem (.clk_sys(clk_sys), .reset(reset), .memReq(memReq),
    .memAddr(memAddr), .memSize(memSize), .memAck(memAck), .memRdata(memRdata),
    .addr0(addr0), .ent0(ent0), .ent1(ent1), .lat(lat));

  always #5 clk_sys = ~clk_sys;

  task printVerdict();
    if (badCount == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      badCount++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one apb transfer; an idle edge first keeps strobes from toggling twice
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  // reference result {dest, x n z v c}; entry mix avoids a signed difference
  function automatic logic [36:0] gold(input logic [31:0] lo, hi, d, input logic [1:0] sz,
    input logic r);
    logic [31:0] m, q, rr;
    logic [41:0] v;
    m = (sz == 2'b00) ? 32'hff : (sz == 2'b01) ? 32'hffff : 32'hffff_ffff;
    v = 42'(lo & m) * 42'(9'h100 - d[7:0]) + 42'(hi & m) * 42'(d[7:0]);
    rr = 32'((v + 42'h80) >> 8);
    q = r ? v[31:0] & ((m << 8) | 32'hff) : (d & ~m) | (rr & m);
    return {q, 1'b1, r ? q[31] : (sz == 2'b00) ? q[7] : (sz == 2'b01) ? q[15] : q[31],
      r ? q == 32'h0 : (q & m) == 32'h0, r && sz == 2'b10 && v[41:32] != 10'h0, 1'b0};
  endfunction

  // full operation: load, start, wait for idle, check result, flags and irq
  task op(input logic [5:0] ea, input logic [15:0] ew, input logic [31:0] d, m, n);
    logic [36:0] g;
    int          i;
    addr0 = 32'h1000 + (32'(d[15:8]) << ew[7:6]);
    xfer(1'b1, OFS_OPWORD, {16'h0, OPWORD_MATCH, ea});
    xfer(1'b1, OFS_EXTWORD, {16'h0, ew});
    xfer(1'b1, OFS_DEST, d);
    xfer(1'b1, OFS_EABASE, 32'h1000);
    xfer(1'b1, OFS_ENDPT_M, m);
    xfer(1'b1, OFS_ENDPT_N, n);
    xfer(1'b1, OFS_CCR, 32'h1f);
    xfer(1'b1, OFS_CTRL, 32'h1);
    i = 0;
    rdv = 32'h1;
    while (rdv[0] !== 1'b0 && i < 40)
    begin
      xfer(1'b0, OFS_CTRL, 32'h0);
      i++;
    end
    chk("busy", 32'h0, rdv);
    g = gold(ew[8] ? ent0 : m, ew[8] ? ent1 : n, d, ew[7:6], ew[10]);
    xfer(1'b0, OFS_DEST, 32'h0);
    chk("dest", g[36:5], rdv);
    xfer(1'b0, OFS_CCR, 32'h0);
    chk("ccr", {27'h0, g[4:0]}, rdv);
    chk("irq", {31'h0, irqOn}, {31'h0, irq});
    xfer(1'b0, OFS_IRQ_STAT, 32'h0);
    chk("stat", 32'h1, rdv);
    @(posedge clk_sys);
    chk("irqclr", 32'h0, {31'h0, irq});
  endtask

  // refused operation raises the illegal event only
  task ill(input logic [5:0] ea, input logic [15:0] ew);
    xfer(1'b1, OFS_OPWORD, {16'h0, OPWORD_MATCH, ea});
    xfer(1'b1, OFS_EXTWORD, {16'h0, ew});
    xfer(1'b1, OFS_CTRL, 32'h1);
    repeat (2) @(posedge clk_sys);
    chk("irqill", 32'h1, {31'h0, irq});
    xfer(1'b0, OFS_IRQ_STAT, 32'h0);
    chk("illegal", 32'h2, rdv);
  endtask

  initial
  begin
    repeat (20000) @(posedge clk_sys);
    badCount++;
    printVerdict();
  end

  initial
  begin
    {reset, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
    {addr0, ent0, ent1, lat, irqOn} = {100'h0, 1'b1};
    repeat (6) @(posedge clk_sys);
    reset <= 1'b0;
    xfer(1'b0, OFS_DEST, 32'h0);
    chk("rstdest", RST_WORD, rdv);
    xfer(1'b0, OFS_CCR, 32'h0);
    chk("rstccr", 32'h0, rdv);
    xfer(1'b0, 8'h40, 32'h0);
    chk("unmapped", 32'h1, {31'h0, errv});
    xfer(1'b1, OFS_IRQ_MASK, 32'h3);
    xfer(1'b0, OFS_IRQ_MASK, 32'h0);
    chk("mask", 32'h3, rdv);
    // register mode: rounding at and below one half with upper bits kept, then an unrounded word with upper bits cleared
    op(6'h01, 16'h0002, 32'h1234_ff80, 32'hffff_ff10, 32'h11);
    op(6'h01, 16'h0002, 32'h1234_ff7f, 32'hffff_ff10, 32'h11);
    op(6'h02, 16'h0443, 32'hdead_0140, 32'h100, 32'h300);
    // table modes, slow and prompt memory, equal and descending entries
    {ent0, ent1, lat} = {32'h0200_0000, 32'h0200_0000, 4'h0};
    op(6'h33, 16'h0580, 32'h0000_0201, 32'h0, 32'h0);
    {ent0, ent1, lat} = {32'h1111_8000, 32'h2222_7000, 4'h3};
    op(6'h3b, 16'h0140, 32'habcd_0305, 32'h0, 32'h0);
    {ent0, ent1, lat} = {32'hffff_ff90, 32'h0000_0010, 4'h1};
    op(6'h2c, 16'h0500, 32'hffff_ff40, 32'h0, 32'h0);
    // masked done event leaves irq low
    xfer(1'b1, OFS_IRQ_MASK, 32'h0);
    irqOn = 1'b0;
    {ent0, ent1, lat} = {32'h8000_0000, 32'hffff_ffff, 4'h2};
    op(6'h10, 16'h0180, 32'h0000_00ff, 32'h0, 32'h0);
    xfer(1'b1, OFS_IRQ_MASK, 32'h3);
    ill(6'h18, 16'h0100);
    ill(6'h3c, 16'h0100);
    ill(6'h00, 16'h0100);
    ill(6'h10, 16'h01c0);
    ill(6'h10, 16'h0900);
    printVerdict();
  end
endmodule // unsigned_table_interpolate_bench
`default_nettype wire

/* tb/unsigned_table_interpolate_chk.sv */
// port checker of the unsigned table interpolate datapath
`timescale 1ns/10ps
`default_nettype none
module unsigned_table_interpolate_chk
  import tbl_interp_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  // watched ports
  input  wire logic              clk_sys,
  input  wire logic              reset,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       prdata,
  input  wire logic              pready,
  input  wire logic              pslverr,
  input  wire logic              memReq,
  input  wire logic [31:0]       memAddr,
  input  wire logic [1:0]        memSize,
  input  wire logic              memAck
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  wire acc = psel && penable;

  // entry n taken while the port keeps asking
  sequence s_firstTaken;
    memReq && memAck ##1 memReq;
  endsequence
  // last entry taken and the port has let go
  sequence s_lastTaken;
    memReq && memAck ##1 !memReq;
  endsequence

  a_zero_wait: assert property (pready) else $error("pready low");
  a_unmapped_err: assert property (acc && paddr > OFS_IRQ_MASK |-> pslverr
    && (pwrite || prdata == 32'h0)) else $error("unmapped access not refused");
  a_mapped_ok: assert property (acc && paddr <= OFS_IRQ_MASK && paddr[1:0] == 2'h0
    |-> !pslverr) else $error("mapped access refused");
  a_req_hold: assert property (memReq && !memAck |=> memReq && $stable(memAddr)
    && $stable(memSize)) else $error("entry request dropped or moved");
  a_next_entry: assert property (s_firstTaken |-> memAddr ==
    $past(memAddr) + (32'h1 << $past(memSize))) else $error("second entry address");
  a_size_legal: assert property (memReq |-> memSize != 2'b11)
    else $error("illegal entry size requested");
  a_calc_gap: assert property (s_lastTaken |=> !memReq)
    else $error("request right after last entry");
  a_ccr_bits: assert property (acc && !pwrite && paddr == OFS_CCR
    |-> prdata[31:CCR_W] == 27'h0 && !prdata[CCR_C]) else $error("ccr read bits");
endmodule // unsigned_table_interpolate_chk
bind unsigned_table_interpolate unsigned_table_interpolate_chk #(.ADDR_W(ADDR_W)) i_chk
(
  .clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .memReq(memReq), .memAddr(memAddr), .memSize(memSize), .memAck(memAck)
);
`default_nettype wire
